/* qdc_map.svh */
// qdc_map.svh: frame field positions, codes and reset values of the
// quad converter command decoder; definitions only, no logic.
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH

`define QDC_FRAME_BITS    24
`define QDC_RW_BIT        23
`define QDC_SEL_HI        21
`define QDC_SEL_LO        19
`define QDC_CHAN_HI       18
`define QDC_CHAN_LO       16

`define QDC_SEL_DATA      3'h0
`define QDC_SEL_RANGE     3'h1
`define QDC_SEL_POWER     3'h2
`define QDC_SEL_CTRL      3'h3

`define QDC_CTRL_NOP      3'h0
`define QDC_CTRL_SETUP    3'h1
`define QDC_CTRL_CLEAR    3'h4
`define QDC_CTRL_LOAD     3'h5

`define QDC_CHAN_ALL      3'h4

`define QDC_BIT_THERM_EN  3
`define QDC_BIT_CLAMP_EN  2
`define QDC_BIT_CLEAR_SEL 1
`define QDC_BIT_SEROUT_OFF 0

`define QDC_PWR_OC_LO     7
`define QDC_PWR_THERM     5

`define QDC_RANGE_MAX     3'h5
`define QDC_RANGE_BIP_MIN 3'h3

`define QDC_RST_CODE      16'h0000
`define QDC_RST_RANGE     3'h0
`define QDC_RST_SETTINGS  4'h4
`define QDC_RST_POWER     4'h0

`define QDC_CODE_ZERO     16'h0000
`define QDC_CODE_MID      16'h8000

`endif

/* qdc_pkg.sv */
// qdc_pkg.sv: types shared by the command decoder files.
// assumes qdc_map.svh holds the numeric constants.
package qdc_pkg;
	typedef logic [15:0] qdc_word_t;
	typedef enum {RX_IDLE, RX_SHIFT, RX_DONE} qdc_rx_state_t;
endpackage

/* qdc_frame_if.sv */
// qdc_frame_if.sv: carries received frames from the serial receiver
// to the decoder; both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface qdc_frame_if;
	logic [23:0] word;
	logic        valid;
	logic        bitStrobe;
	modport rx  (output word, output valid, output bitStrobe);
	modport dec (input word, input valid, input bitStrobe);
endinterface
`default_nettype wire

/* qdc_frame_rx.sv */
// qdc_frame_rx.sv: serial frame receiver; samples the host link pins
// with core_clk and assembles 24-bit words, msb first.
// assumes core_clk runs several times faster than the link clock.
`timescale 1ns/1ps
`default_nettype none
`include "qdc_map.svh"
module qdc_frame_rx (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic sclk,
	input  wire logic syncN,
	input  wire logic sdin,
	qdc_frame_if.rx   frm
);
	import qdc_pkg::*;

	logic [1:0]    sclkSync;
	logic [1:0]    selSync;
	logic [1:0]    dinSync;
	logic          sclkPrev;
	logic [4:0]    bitCount;
	qdc_rx_state_t state;
	wire           sclkFall = sclkPrev & ~sclkSync[1];
	wire           lastBit  = bitCount == 5'(`QDC_FRAME_BITS - 1);

	always_ff @(posedge core_clk) begin
		sclkSync <= {sclkSync[0], sclk};
		selSync  <= {selSync[0], syncN};
		dinSync  <= {dinSync[0], sdin};
		sclkPrev <= sclkSync[1];
	end

	// a frame cut short by a rising select raises no valid, though its bits still strobe the reply shift
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state         <= RX_IDLE;
			bitCount      <= 5'h00;
			frm.word      <= 24'h00_0000;
			frm.valid     <= 1'b0;
			frm.bitStrobe <= 1'b0;
		end else begin
			frm.valid     <= 1'b0;
			frm.bitStrobe <= 1'b0;
			case (state)
				RX_IDLE: begin
					bitCount <= 5'h00;
					if (!selSync[1])
						state <= RX_SHIFT;
				end
				RX_SHIFT: begin
					if (selSync[1]) begin
						state <= RX_IDLE;
					end else if (sclkFall) begin
						frm.word      <= {frm.word[22:0], dinSync[1]};
						frm.bitStrobe <= 1'b1;
						bitCount      <= bitCount + 5'h01;
						if (lastBit) begin
							frm.valid <= 1'b1;
							state     <= RX_DONE;
						end
					end
				end
				RX_DONE: begin
					if (selSync[1])
						state <= RX_IDLE;
				end
				default: state <= RX_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* qdc_command_decoder.sv */
// qdc_command_decoder.sv: quad converter command decoder top; decodes
// host frames into channel data, ranges, control and power settings.
// assumes link pins are asynchronous and sampled by core_clk; analog
// alarms (overcurrent, overtemperature) are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
`include "qdc_map.svh"
// Behaviour
// - select 000 writes channel data; address picks the channel
// - data left-justified; 14/12-bit variants ignore low bits
// - select 001 sets addressed channel range from data bits 2..0
// - range codes 000..101 map to +5,+10,+10.8,+-5,+-10,+-10.8 V
// - select 011 picks control function from address and data
// - control address 000 is a no-operation changing no state
// - control address 100 loads clear code into all channels now
// - control address 101 moves buffered inputs to channel outputs
// - control address 001 stores four settings from data bits 3..0
// - serial-output disable set stops driving the serial output
// - clamp enabled (default): overcurrent limits current, no power-down
// - clamp disabled: overcurrent powers the channel down
// - thermal shutdown acts only when enabled; disabled by default
// - clear code: select 0 gives 0 V; 1 midscale or negative full
// - select 010 addresses the power control register
// - address 000..011 picks channel A..D, 100 all four
module qdc_command_decoder #(
	parameter int DATA_BITS = 16
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       syncN,
	input  wire logic       sdin,
	output logic            serial_data_output,
	output logic            sdoOe,
	input  wire logic [3:0] overCurrent,
	input  wire logic       overTemp,
	output var qdc_pkg::qdc_word_t dacCode [4],
	output logic [11:0]     dacRange,
	output logic [3:0]      channelPowerUp,
	output logic [3:0]      currentLimit,
	output logic            thermalEnable,
	output logic            clampEnable,
	output logic            clearSelect,
	output logic            thermalAlert
);
	import qdc_pkg::*;

	// low bits cleared so a narrow variant never holds stray data
	localparam qdc_word_t DATA_MASK = 16'hFFFF << (16 - DATA_BITS);
	localparam logic [3:0] RST_POWER = `QDC_RST_POWER;

	qdc_frame_if frm ();

	qdc_frame_rx u_rx (
		.core_clk (core_clk),
		.rst      (rst),
		.sclk     (sclk),
		.syncN    (syncN),
		.sdin     (sdin),
		.frm      (frm)
	);

	// alarm pins cross from the analog side
	logic [3:0] ocMeta;
	logic [3:0] ocSync;
	logic [1:0] otSync;
	always_ff @(posedge core_clk) begin
		ocMeta <= overCurrent;
		ocSync <= ocMeta;
		otSync <= {otSync[0], overTemp};
	end
	wire overTempHit = otSync[1] & thermalEnable;

	// frame field decode
	wire       isRead    = frm.word[`QDC_RW_BIT];
	wire [2:0] regSel    = frm.word[`QDC_SEL_HI:`QDC_SEL_LO];
	wire [2:0] chanSel   = frm.word[`QDC_CHAN_HI:`QDC_CHAN_LO];
	wire [15:0] wordData = frm.word[15:0];
	wire       writeOk   = frm.valid & ~isRead;
	wire       dataWr    = writeOk & (regSel == `QDC_SEL_DATA);
	wire       rangeWr   = writeOk & (regSel == `QDC_SEL_RANGE) &
	                       (wordData[2:0] <= `QDC_RANGE_MAX);
	wire       powerWr   = writeOk & (regSel == `QDC_SEL_POWER);
	wire       ctrlWr    = writeOk & (regSel == `QDC_SEL_CTRL);
	wire       setupWr   = ctrlWr & (chanSel == `QDC_CTRL_SETUP);
	wire       clearCmd  = ctrlWr & (chanSel == `QDC_CTRL_CLEAR);
	wire       loadCmd   = ctrlWr & (chanSel == `QDC_CTRL_LOAD);
	// address 000 under control select matches none of the above

	// control settings
	logic sdoDisable;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{thermalEnable, clampEnable, clearSelect, sdoDisable} <=
				`QDC_RST_SETTINGS;
		end else if (setupWr) begin
			thermalEnable <= wordData[`QDC_BIT_THERM_EN];
			clampEnable   <= wordData[`QDC_BIT_CLAMP_EN];
			clearSelect   <= wordData[`QDC_BIT_CLEAR_SEL];
			sdoDisable    <= wordData[`QDC_BIT_SEROUT_OFF];
		end
	end

	// per channel state
	qdc_word_t  inputReg [4];
	qdc_word_t  clearCode [4];
	logic [2:0] rangeReg [4];
	logic [3:0] chanHit;

	for (genvar i = 0; i < 4; i++) begin : g_chan
		assign chanHit[i] = (chanSel == 3'(i)) |
		                    (chanSel == `QDC_CHAN_ALL);
		wire bipolar = rangeReg[i] >= `QDC_RANGE_BIP_MIN;
		// offset-binary coding: 0 V bipolar sits at midscale
		assign clearCode[i] = (bipolar ^ clearSelect) ?
		                      `QDC_CODE_MID : `QDC_CODE_ZERO;
		assign dacRange[3*i +: 3] = rangeReg[i];

		always_ff @(posedge core_clk) begin
			if (rst) begin
				inputReg[i] <= `QDC_RST_CODE;
				dacCode[i]  <= `QDC_RST_CODE;
				rangeReg[i] <= `QDC_RST_RANGE;
			end else if (clearCmd) begin
				inputReg[i] <= clearCode[i];
				dacCode[i]  <= clearCode[i];
			end else begin
				if (dataWr && chanHit[i])
					inputReg[i] <= wordData & DATA_MASK;
				if (loadCmd)
					dacCode[i] <= inputReg[i];
				if (rangeWr && chanHit[i])
					rangeReg[i] <= wordData[2:0];
			end
		end

		// unclamped overcurrent or overtemperature clears power-up even against a same-cycle write
		always_ff @(posedge core_clk) begin
			if (rst) begin
				channelPowerUp[i] <= RST_POWER[i];
				currentLimit[i]   <= 1'b0;
			end else begin
				currentLimit[i] <= ocSync[i] & clampEnable;
				if (overTempHit || (ocSync[i] && !clampEnable))
					channelPowerUp[i] <= 1'b0;
				else if (powerWr)
					channelPowerUp[i] <= wordData[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			thermalAlert <= 1'b0;
		else
			thermalAlert <= overTempHit;
	end

	// readback: a read frame loads the reply, shifted out next frame
	// a data read shows the input register, so unloaded writes are visible
	wire [1:0] rdChan = chanSel[1:0];
	wire [15:0] powerWord = {5'h00, ocSync, 1'b0, thermalAlert, 1'b0,
	                         channelPowerUp};
	wire [15:0] ctrlWord = {12'h000, thermalEnable, clampEnable,
	                        clearSelect, sdoDisable};
	wire [15:0] replyData =
		(regSel == `QDC_SEL_DATA)  ? inputReg[rdChan] :
		(regSel == `QDC_SEL_RANGE) ? {13'h0000, rangeReg[rdChan]} :
		(regSel == `QDC_SEL_POWER) ? powerWord : ctrlWord;

	logic [23:0] replyShift;
	always_ff @(posedge core_clk) begin
		if (rst)
			replyShift <= 24'h00_0000;
		else if (frm.valid && isRead)
			replyShift <= {frm.word[23:16], replyData};
		else if (frm.bitStrobe)
			replyShift <= {replyShift[22:0], 1'b0};
	end

	assign serial_data_output   = replyShift[23];
	assign sdoOe = ~sdoDisable;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_write(logic [2:0] sel, logic [2:0] adr);
		frm.valid && !isRead && regSel == sel && chanSel == adr;
	endsequence

	// alarms may move power-up at any time, so only quiet cycles count
	sequence s_quiet;
		ocSync == 4'h0 && !overTempHit;
	endsequence

	sequence s_read(logic [2:0] sel, logic [2:0] adr);
		frm.valid && isRead && regSel == sel && chanSel == adr;
	endsequence

	a_data_write: assert property (
		s_write(`QDC_SEL_DATA, 3'h2) |=>
			inputReg[2] == ($past(wordData) & DATA_MASK))
		else $error("channel C input not written from frame data");

	a_data_mask: assert property (
		(inputReg[1] & ~DATA_MASK) == 16'h0000)
		else $error("ignored low data bits reached channel register");

	a_range_write: assert property (
		s_write(`QDC_SEL_RANGE, `QDC_CHAN_ALL) ##0
		(wordData[2:0] <= `QDC_RANGE_MAX) |=>
			rangeReg[3] == $past(wordData[2:0]) &&
			rangeReg[0] == $past(wordData[2:0]))
		else $error("broadcast range write not applied");

	a_range_illegal: assert property (
		s_write(`QDC_SEL_RANGE, `QDC_CHAN_ALL) ##0
		(wordData[2:0] > `QDC_RANGE_MAX) |=>
			$stable(rangeReg[0]))
		else $error("undefined range code was accepted");

	a_nop_hold: assert property (
		s_write(`QDC_SEL_CTRL, `QDC_CTRL_NOP) ##0 s_quiet |=>
			$stable(dacCode[0]) && $stable(inputReg[0]) &&
			$stable(ctrlWord) && $stable(channelPowerUp))
		else $error("no-operation frame changed state");

	a_clear_all: assert property (
		s_write(`QDC_SEL_CTRL, `QDC_CTRL_CLEAR) |=>
			dacCode[0] == $past(clearCode[0]) &&
			dacCode[3] == $past(clearCode[3]))
		else $error("clear command did not load clear code");

	a_load_xfer: assert property (
		s_write(`QDC_SEL_CTRL, `QDC_CTRL_LOAD) |=>
			dacCode[1] == $past(inputReg[1]))
		else $error("load command did not update output");

	a_setup_store: assert property (
		s_write(`QDC_SEL_CTRL, `QDC_CTRL_SETUP) |=>
			ctrlWord[3:0] == $past(wordData[3:0]))
		else $error("control settings not stored");

	a_sdo_off: assert property (
		s_write(`QDC_SEL_CTRL, `QDC_CTRL_SETUP) |=>
			sdoOe == !$past(wordData[`QDC_BIT_SEROUT_OFF]))
		else $error("serial output driven while disabled");

	a_clamp_limit: assert property (
		clampEnable && ocSync[1] && !overTempHit && channelPowerUp[1] &&
		!powerWr |=> channelPowerUp[1] && currentLimit[1])
		else $error("clamped overcurrent powered channel down");

	a_oc_pwrdn: assert property (
		!clampEnable && ocSync[1] |=> !channelPowerUp[1])
		else $error("overcurrent did not power channel down");

	a_therm_off: assert property (
		!thermalEnable |=> !thermalAlert)
		else $error("thermal shutdown acted while disabled");

	a_clear_code: assert property (
		rangeReg[3] >= `QDC_RANGE_BIP_MIN && !clearSelect |->
			clearCode[3] == `QDC_CODE_MID)
		else $error("bipolar 0 V clear code wrong");

	a_power_write: assert property (
		s_write(`QDC_SEL_POWER, 3'h0) ##0 s_quiet |=>
			channelPowerUp == $past(wordData[3:0]))
		else $error("power control write not applied");

	a_data_all: assert property (
		s_write(`QDC_SEL_DATA, `QDC_CHAN_ALL) |=>
			inputReg[0] == ($past(wordData) & DATA_MASK) &&
			inputReg[3] == ($past(wordData) & DATA_MASK))
		else $error("broadcast data write missed a channel");

	a_chan_hold: assert property (
		s_write(`QDC_SEL_DATA, 3'h0) |=> $stable(inputReg[1]))
		else $error("channel A data write reached channel B");

	a_read_nowrite: assert property (
		frm.valid && isRead |=>
			$stable(inputReg[0]) && $stable(rangeReg[0]) &&
			$stable(ctrlWord))
		else $error("read frame changed a register");

	a_reply_data: assert property (
		s_read(`QDC_SEL_DATA, 3'h0) |=>
			replyShift[15:0] == $past(inputReg[0]))
		else $error("read reply does not hold channel A input");

	a_therm_down: assert property (
		overTempHit |=> channelPowerUp == 4'h0 && thermalAlert)
		else $error("overtemperature left a channel powered");

	a_clamp_off: assert property (
		!clampEnable |=> currentLimit == 4'h0)
		else $error("current limit reported with clamp disabled");

	a_clear_unipolar: assert property (
		rangeReg[0] < `QDC_RANGE_BIP_MIN && clearSelect |->
			clearCode[0] == `QDC_CODE_MID)
		else $error("unipolar midscale clear code wrong");
endmodule
`default_nettype wire

/* qdc_host_model.sv */
// qdc_host_model.sv: host side of the serial link, sends 24-bit frames.
// assumes the decoder samples the link pins with its own faster clock.
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model (
	output logic      sclk,
	output logic      syncN,
	output logic      sdin,
	input  wire logic serial_data_output
);
	// half period in ns; raise it for a slow host
	int half = 24;
	// readback word, one bit taken just before each falling edge
	logic [23:0] rdWord = 24'h00_0000;
	// link clock idles high and stands still between frames
	initial begin
		sclk = 1'b1;
		syncN = 1'b1;
		sdin = 1'b0;
	end
	task automatic send(input logic [23:0] w);
		syncN = 1'b0;
		#(half);
		for (int i = 23; i >= 0; i--) begin
			sdin = w[i]; // msb first
			#(half);
			rdWord = {rdWord[22:0], serial_data_output};
			sclk = 1'b0;
			#(half) sclk = 1'b1;
		end
		syncN = 1'b1;
		// released line shows the inverse, so no stale bit looks valid
		sdin = ~sdin;
		#(half);
	endtask
endmodule
`default_nettype wire

/* qdc_command_decoder_test.sv */
// qdc_command_decoder_test.sv: self-checking bench for the decoder.
// assumes the host model drives the link; alarms are driven here.
`timescale 1ns/1ps
`default_nettype none
`include "qdc_map.svh"
module qdc_command_decoder_test;
	import qdc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk, syncN, sdin, serial_data_output, sdoOe, thermalEnable;
	logic        clampEnable, clearSelect, thermalAlert;
	logic        overTemp = 1'b0;
	logic [3:0]  overCurrent = 4'h0;
	logic [3:0]  channelPowerUp, currentLimit;
	logic [11:0] dacRange;
	qdc_word_t   code [4];
	qdc_word_t   code12 [4];
	qdc_word_t   expCode [4];
	logic [2:0]  rng [4];
	logic [31:0] seed = 32'h0000_002b;
	int          error_cnt = 0;
	int          checks = 0;

	always #2.5 core_clk = ~core_clk;

	qdc_host_model host (.sclk(sclk), .syncN(syncN), .sdin(sdin), .serial_data_output(serial_data_output));
	qdc_command_decoder DUT (.core_clk(core_clk), .rst(rst), .sclk(sclk),
		.syncN(syncN), .sdin(sdin), .serial_data_output(serial_data_output), .sdoOe(sdoOe),
		.overCurrent(overCurrent), .overTemp(overTemp), .dacCode(code),
		.dacRange(dacRange), .channelPowerUp(channelPowerUp),
		.currentLimit(currentLimit), .thermalEnable(thermalEnable),
		.clampEnable(clampEnable), .clearSelect(clearSelect),
		.thermalAlert(thermalAlert));
	// 12-bit variant hears the same frames
	qdc_command_decoder #(.DATA_BITS(12)) DUT12 (.core_clk(core_clk),
		.rst(rst), .sclk(sclk), .syncN(syncN), .sdin(sdin), .serial_data_output(),
		.sdoOe(), .overCurrent(overCurrent), .overTemp(overTemp),
		.dacCode(code12), .dacRange(), .channelPowerUp(), .currentLimit(),
		.thermalEnable(), .clampEnable(), .clearSelect(), .thermalAlert());

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// bipolar ranges are offset binary, so 0 V sits at midscale
	function automatic qdc_word_t clrCode(logic [2:0] r, logic s);
		return ((r >= `QDC_RANGE_BIP_MIN) ^ s) ? 16'h8000 : 16'h0000;
	endfunction

	task automatic chk(string name, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wr(logic [2:0] sel, logic [2:0] a, logic [15:0] d);
		host.send({2'b00, sel, a, d});
		repeat (10) @(posedge core_clk);
	endtask
	task automatic chkCodes();
		for (int i = 0; i < 4; i++) begin
			chk("dacCode", expCode[i], code[i]);
			chk("dacCode12", expCode[i] & 16'hfff0, code12[i]);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#400_000;
		error_cnt++;
		final_report();
	end

	initial begin
		logic [15:0] d;
		logic [3:0]  s;
		repeat (20) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge core_clk);
		chk("clampEnable", 16'(1'b1), 16'(clampEnable));
		chk("thermalEnable", 16'(1'b0), 16'(thermalEnable));
		chk("sdoOe", 16'(1'b1), 16'(sdoOe));
		wr(`QDC_SEL_RANGE, `QDC_CHAN_ALL, 16'h0005);
		chk("dacRange", 16'({4{3'h5}}), 16'(dacRange));
		for (int i = 0; i < 4; i++) begin
			expCode[i] = 16'h0000;
			rng[i] = 3'((i < 2) ? rnd() % 3 : 3 + rnd() % 3);
			d = 16'(rnd());
			wr(`QDC_SEL_RANGE, 3'(i), {d[15:3], rng[i]});
		end
		// code 110 has no range and must be dropped
		wr(`QDC_SEL_RANGE, `QDC_CHAN_ALL, 16'h0006);
		for (int i = 0; i < 4; i++)
			chk("dacRange", 16'(rng[i]), 16'(dacRange[3*i+:3]));
		for (int i = 0; i < 5; i++) begin
			d = 16'(rnd());
			wr(`QDC_SEL_DATA, 3'(i), d);
			chkCodes();
			wr(`QDC_SEL_CTRL, `QDC_CTRL_LOAD, 16'(rnd()));
			for (int c = 0; c < 4; c++)
				if (i == c || i == 4)
					expCode[c] = d;
			chkCodes();
		end
		host.half = 60;
		host.send({2'b10, `QDC_SEL_DATA, 3'h0, ~expCode[0]});
		host.half = 24;
		repeat (10) @(posedge core_clk);
		wr(`QDC_SEL_CTRL, `QDC_CTRL_NOP, 16'hffff);
		chk("readHeader", 16'h0080, 16'(host.rdWord[23:16]));
		chk("readData", expCode[0], host.rdWord[15:0]);
		wr(`QDC_SEL_CTRL, `QDC_CTRL_LOAD, 16'(rnd()));
		chkCodes();
		chk("clampEnable", 16'(1'b1), 16'(clampEnable));
		for (int k = 0; k < 4; k++) begin
			d = 16'(rnd());
			s = {d[3:2], 2'(k)};
			wr(`QDC_SEL_CTRL, `QDC_CTRL_SETUP, {d[15:4], s});
			chk("thermalEnable", 16'(s[3]), 16'(thermalEnable));
			chk("clampEnable", 16'(s[2]), 16'(clampEnable));
			chk("clearSelect", 16'(s[1]), 16'(clearSelect));
			chk("sdoOe", 16'(!s[0]), 16'(sdoOe));
			wr(`QDC_SEL_CTRL, `QDC_CTRL_CLEAR, 16'(rnd()));
			for (int c = 0; c < 4; c++)
				expCode[c] = clrCode(rng[c], s[1]);
			chkCodes();
		end
		wr(`QDC_SEL_CTRL, `QDC_CTRL_SETUP, 16'h0004);
		wr(`QDC_SEL_POWER, 3'h0, 16'h000f);
		chk("channelPowerUp", 16'(4'hf), 16'(channelPowerUp));
		d = 16'(rnd());
		@(posedge core_clk);
		#1 overCurrent = d[3:0] | 4'h2;
		overTemp = 1'b1;
		repeat (10) @(posedge core_clk);
		chk("currentLimit", 16'(overCurrent), 16'(currentLimit));
		chk("channelPowerUp", 16'(4'hf), 16'(channelPowerUp));
		chk("thermalAlert", 16'(1'b0), 16'(thermalAlert));
		wr(`QDC_SEL_CTRL, `QDC_CTRL_SETUP, 16'h0000);
		chk("channelPowerUp", 16'(4'(~overCurrent)), 16'(channelPowerUp));
		wr(`QDC_SEL_CTRL, `QDC_CTRL_SETUP, 16'h0008);
		chk("channelPowerUp", 16'(4'h0), 16'(channelPowerUp));
		chk("thermalAlert", 16'(1'b1), 16'(thermalAlert));
		final_report();
	end
endmodule
`default_nettype wire
